// >>> src/ccu_map.vh
// Register map, flag layout, opcodes and cycle counts of the execution unit
`ifndef CCU_MAP_VH
`define CCU_MAP_VH
// Bus byte offsets
`define CCU_OFS_INSTR 12'h000
`define CCU_OFS_STATUS 12'h004
`define CCU_OFS_FLAGS 12'h008
`define CCU_OFS_RPTR 12'h00C
`define CCU_RF_BASE 2'h1
// Instruction word fields
`define CCU_F_OPC 7:0
`define CCU_F_B1 15:8
`define CCU_F_B2 23:16
// Flag bit positions in the flag byte
`define CCU_FL_C 7
`define CCU_FL_Z 6
`define CCU_FL_S 5
`define CCU_FL_V 4
`define CCU_FL_D 3
`define CCU_FL_H 2
`define CCU_FL_RESET 8'h00
// Status bits
`define CCU_ST_BUSY 0
`define CCU_ST_BADOP 1
// Opcodes
`define CCU_OP_CTOG 8'hEF
`define CCU_OP_ZF_R 8'h80
`define CCU_OP_ZF_IR 8'h81
`define CCU_OP_INV_R 8'h60
`define CCU_OP_INV_IR 8'h61
`define CCU_OP_DA_R 8'h40
`define CCU_OP_DA_IR 8'h41
`define CCU_OP_CP_RR 8'hA2
`define CCU_OP_CP_RIR 8'hA3
`define CCU_OP_CP_RGRG 8'hA4
`define CCU_OP_CP_RGIR 8'hA5
`define CCU_OP_CP_RGIM 8'hA6
`define CCU_OP_CP_IRIM 8'hA7
// Cycle counts
`define CCU_CYC_SHORT 4'h6
`define CCU_CYC_DA 4'h8
`define CCU_CYC_LONG 4'hA
`define CCU_CYC_BAD 4'h1
// Working register shorthand and decimal corrections
`define CCU_WR_TAG 4'hE
`define CCU_BCD_MAX 4'h9
`define CCU_BCD_BYTE_MAX 8'h99
`define CCU_DA_LO 8'h06
`define CCU_DA_HI 8'h60
`define CCU_DA_SUB_LO 8'hFA
`define CCU_DA_SUB_HI 8'hA0
`define CCU_DA_SUB_BOTH 8'h9A
`define CCU_ZERO 8'h00
`endif

// >>> src/ccu_exec.v
// Execution unit for carry toggle, zero fill, invert, compare and decimal adjust
// Function
// - Carry toggle EF takes 6 cycles, inverts carry, keeps other flags.
// - Zero fill 80 direct, 81 indirect, writes 00h in 6 cycles, flags kept.
// - Invert 60 direct, 61 indirect, writes one's complement in 6 cycles.
// - Invert: Z on zero result, S is bit 7, V cleared, others kept.
// - Compare A2-A7; A2, A3 take 6 cycles, A4-A7 take 10.
// - Compare subtracts source from destination and writes nothing back.
// - Compare carry cleared on carry out of bit 7, else set.
// - Compare V on signed overflow; D and H kept.
// - Compare Z on zero difference, S copies difference bit 7.
// - Operand byte with high nibble 1110b names a working register.
// - Decimal adjust adds a correction picked from C, H and nibbles.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "ccu_map.vh"
module ccu_exec #(
   parameter AW = 12
) (
   input wire CLK,
   input wire RST,
   input wire [AW-1:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output reg AVS_WAITREQUEST,
   output reg [7:0] FLAGS,
   output reg BUSY
);

   // Operand byte to register address, honouring working register shorthand
   function [7:0] ccu_resolve;
      input [7:0] b;
      input [3:0] rp;
      begin
         if (b[7:4] == `CCU_WR_TAG) begin
            ccu_resolve = {rp, b[3:0]};
         end else begin
            ccu_resolve = b;
         end
      end
   endfunction

   // Zero and sign flags of a result byte
   function [1:0] ccu_zs;
      input [7:0] r;
      begin
         ccu_zs = {(r == `CCU_ZERO), r[7]};
      end
   endfunction

   // Nine-bit sum with carry in; the top bit is the carry out of bit 7
   function [8:0] ccu_add9;
      input [7:0] a;
      input [7:0] b;
      input cin;
      begin
         ccu_add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      end
   endfunction

   // Register file is not reset: software must load what it later reads
   reg [7:0] rf [0:255];
   reg [23:0] instr_ff;
   reg [3:0] rp_ff;
   reg [3:0] cnt_ff;
   reg badop_ff;
   reg [7:0] flags_ff;

   reg [3:0] nxt_cnt;
   reg [7:0] dst_a;
   reg [7:0] dval;
   reg [7:0] sval;
   reg [7:0] wval;
   reg do_wr;
   reg valid_op;
   reg [7:0] nxt_flags;
   reg [8:0] diff;
   reg [7:0] corr;
   reg [8:0] dsum;
   reg [1:0] zs;

   wire [7:0] opc = instr_ff[`CCU_F_OPC];
   wire [7:0] b1 = instr_ff[`CCU_F_B1];
   wire [7:0] b2 = instr_ff[`CCU_F_B2];
   wire [7:0] r1 = ccu_resolve(b1, rp_ff);
   wire [7:0] r2 = ccu_resolve(b2, rp_ff);
   wire [7:0] wr_hi = {rp_ff, b1[7:4]};
   wire [7:0] wr_lo = {rp_ff, b1[3:0]};
   wire last = BUSY && (cnt_ff == 4'h1);

   // Bus handshake: a request is taken one cycle after it shows and the bus
   // stalls while an instruction runs, so no bus write meets a write-back
   wire req = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !BUSY;
   wire in_rf = (AVS_ADDRESS[AW-1:AW-2] == `CCU_RF_BASE);
   wire [7:0] rf_a = AVS_ADDRESS[9:2];
   wire is_instr = AVS_ADDRESS == `CCU_OFS_INSTR;
   wire issue = req && AVS_WRITE && is_instr;

   // Cycle count of the opcode being issued
   always @* begin
      case (AVS_WRITEDATA[`CCU_F_OPC])
         `CCU_OP_CTOG: nxt_cnt = `CCU_CYC_SHORT;
         `CCU_OP_ZF_R, `CCU_OP_ZF_IR: nxt_cnt = `CCU_CYC_SHORT;
         `CCU_OP_INV_R, `CCU_OP_INV_IR: nxt_cnt = `CCU_CYC_SHORT;
         `CCU_OP_DA_R, `CCU_OP_DA_IR: nxt_cnt = `CCU_CYC_DA;
         `CCU_OP_CP_RR, `CCU_OP_CP_RIR: nxt_cnt = `CCU_CYC_SHORT;
         `CCU_OP_CP_RGRG, `CCU_OP_CP_RGIR: nxt_cnt = `CCU_CYC_LONG;
         `CCU_OP_CP_RGIM, `CCU_OP_CP_IRIM: nxt_cnt = `CCU_CYC_LONG;
         default: nxt_cnt = `CCU_CYC_BAD;
      endcase
   end

   // Operand fetch and result computation, used on the final cycle only
   always @* begin
      dst_a = r1;
      sval = `CCU_ZERO;
      wval = `CCU_ZERO;
      do_wr = 1'b0;
      valid_op = 1'b1;
      nxt_flags = flags_ff;
      diff = 9'h000;
      corr = `CCU_ZERO;
      dsum = 9'h000;
      zs = 2'b00;
      case (opc)
         // Carry toggle touches no register
         `CCU_OP_CTOG: begin
            nxt_flags[`CCU_FL_C] = ~flags_ff[`CCU_FL_C];
         end
         // Direct forms: the operand byte is the address
         `CCU_OP_ZF_R, `CCU_OP_INV_R, `CCU_OP_DA_R: begin
            dst_a = r1;
         end
         // Indirect forms: the named register holds the address
         `CCU_OP_ZF_IR, `CCU_OP_INV_IR, `CCU_OP_DA_IR: begin
            dst_a = rf[r1];
         end
         // Working register pair packed in one byte, destination high nibble
         `CCU_OP_CP_RR: begin
            dst_a = wr_hi;
            sval = rf[wr_lo];
         end
         `CCU_OP_CP_RIR: begin
            dst_a = wr_hi;
            sval = rf[rf[wr_lo]];
         end
         // Long forms carry the source first and the destination second
         `CCU_OP_CP_RGRG: begin
            dst_a = r2;
            sval = rf[r1];
         end
         `CCU_OP_CP_RGIR: begin
            dst_a = r2;
            sval = rf[rf[r1]];
         end
         // Literal source comes straight from the instruction word
         `CCU_OP_CP_RGIM: begin
            dst_a = r1;
            sval = b2;
         end
         `CCU_OP_CP_IRIM: begin
            dst_a = rf[r1];
            sval = b2;
         end
         // Unknown opcode: a one-cycle no-op that marks itself invalid
         default: begin
            valid_op = 1'b0;
         end
      endcase
      // One read port serves every destination operand
      dval = rf[dst_a];
      case (opc)
         // Zero fill leaves every flag alone
         `CCU_OP_ZF_R, `CCU_OP_ZF_IR: begin
            do_wr = 1'b1;
            wval = `CCU_ZERO;
         end
         // Complement result decides Z and S; V is forced low
         `CCU_OP_INV_R, `CCU_OP_INV_IR: begin
            do_wr = 1'b1;
            wval = ~dval;
            zs = ccu_zs(~dval);
            nxt_flags[`CCU_FL_Z] = zs[1];
            nxt_flags[`CCU_FL_S] = zs[0];
            nxt_flags[`CCU_FL_V] = 1'b0;
         end
         `CCU_OP_DA_R, `CCU_OP_DA_IR: begin
            // D marks a preceding subtraction; V is left as it was
            if (flags_ff[`CCU_FL_D]) begin
               if (flags_ff[`CCU_FL_C] && flags_ff[`CCU_FL_H]) begin
                  corr = `CCU_DA_SUB_BOTH;
               end else if (flags_ff[`CCU_FL_C]) begin
                  corr = `CCU_DA_SUB_HI;
               end else if (flags_ff[`CCU_FL_H]) begin
                  corr = `CCU_DA_SUB_LO;
               end
               nxt_flags[`CCU_FL_C] = flags_ff[`CCU_FL_C];
            end else begin
               if (flags_ff[`CCU_FL_H] || (dval[3:0] > `CCU_BCD_MAX)) begin
                  corr = corr | `CCU_DA_LO;
               end
               if (flags_ff[`CCU_FL_C] || (dval > `CCU_BCD_BYTE_MAX)) begin
                  corr = corr | `CCU_DA_HI;
               end
               nxt_flags[`CCU_FL_C] = corr[6];
            end
            dsum = ccu_add9(dval, corr, 1'b0);
            do_wr = 1'b1;
            wval = dsum[7:0];
            zs = ccu_zs(dsum[7:0]);
            nxt_flags[`CCU_FL_Z] = zs[1];
            nxt_flags[`CCU_FL_S] = zs[0];
         end
         `CCU_OP_CP_RR, `CCU_OP_CP_RIR, `CCU_OP_CP_RGRG,
         `CCU_OP_CP_RGIR, `CCU_OP_CP_RGIM, `CCU_OP_CP_IRIM: begin
            // Two's complement subtract; no write-back at all
            diff = ccu_add9(dval, ~sval, 1'b1);
            zs = ccu_zs(diff[7:0]);
            nxt_flags[`CCU_FL_C] = ~diff[8];
            nxt_flags[`CCU_FL_V] = (dval[7] != sval[7]) && (diff[7] != dval[7]);
            nxt_flags[`CCU_FL_Z] = zs[1];
            nxt_flags[`CCU_FL_S] = zs[0];
         end
         default: begin
            do_wr = 1'b0;
         end
      endcase
   end

   // Register file: bus writes while idle, result write-back on last cycle
   always @(posedge CLK) begin
      if (req && AVS_WRITE && in_rf && AVS_BYTEENABLE[0]) begin
         rf[rf_a] <= AVS_WRITEDATA[7:0];
      end else if (last && do_wr) begin
         rf[dst_a] <= wval;
      end
   end

   // Control state, flags and bus answer
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         instr_ff <= 24'h000000;
         rp_ff <= 4'h0;
         cnt_ff <= 4'h0;
         badop_ff <= 1'b0;
         flags_ff <= `CCU_FL_RESET;
         FLAGS <= `CCU_FL_RESET;
         BUSY <= 1'b0;
         AVS_READDATA <= 32'h00000000;
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         AVS_WAITREQUEST <= !req;
         // Read mux; the word stands from the cycle waitrequest goes low
         if (req && AVS_READ) begin
            if (in_rf) begin
               AVS_READDATA <= {24'h000000, rf[rf_a]};
            end else if (AVS_ADDRESS == `CCU_OFS_INSTR) begin
               AVS_READDATA <= {8'h00, instr_ff};
            end else if (AVS_ADDRESS == `CCU_OFS_STATUS) begin
               AVS_READDATA <= {30'h0, badop_ff, BUSY};
            end else if (AVS_ADDRESS == `CCU_OFS_FLAGS) begin
               AVS_READDATA <= {24'h000000, flags_ff};
            end else if (AVS_ADDRESS == `CCU_OFS_RPTR) begin
               AVS_READDATA <= {28'h0000000, rp_ff};
            end else begin
               AVS_READDATA <= 32'h00000000; // Unmapped reads as zero
            end
         end
         // Flag and pointer writes need byte lane 0; only legal while idle
         if (req && AVS_WRITE && AVS_BYTEENABLE[0]) begin
            if (AVS_ADDRESS == `CCU_OFS_FLAGS) begin
               flags_ff <= AVS_WRITEDATA[7:0];
               FLAGS <= AVS_WRITEDATA[7:0];
            end
            if (AVS_ADDRESS == `CCU_OFS_RPTR) begin
               rp_ff <= AVS_WRITEDATA[3:0];
            end
         end
         // Issue holds the instruction for its whole documented duration
         if (issue) begin
            instr_ff <= AVS_WRITEDATA[23:0];
            cnt_ff <= nxt_cnt;
            BUSY <= 1'b1;
         end else if (BUSY) begin
            cnt_ff <= cnt_ff - 4'h1;
            // Flags and the invalid mark move only as an instruction ends
            if (last) begin
               BUSY <= 1'b0;
               badop_ff <= !valid_op;
               flags_ff <= nxt_flags;
               FLAGS <= nxt_flags;
            end
         end
      end
   end

endmodule // ccu_exec

// >>> bench/ccu_exec_chk.sv
// Checker for bus handshake, busy length and flag updates of the execution unit
`timescale 1ns/1ps
module ccu_exec_chk #(parameter AW = 12) (
   input wire CLK,
   input wire RST,
   input wire [AW-1:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   input wire [31:0] AVS_READDATA,
   input wire AVS_WAITREQUEST,
   input wire [7:0] FLAGS,
   input wire BUSY
);
   reg [7:0] opc_ff;
   reg [3:0] cnt_ff;
   wire take = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & ~BUSY;
   wire issue = take & AVS_WRITE & ~|AVS_ADDRESS;
   // Own cycle table, so a wrong design table cannot hide behind a shared one
   function [3:0] cyc(input [7:0] o);
      cyc = (o[7:2] == 6'h29) ? 4'hA : (o[7:1] == 7'h20) ? 4'h8 : (o == 8'hEF
         || o[7:1] == 7'h40 || o[7:1] == 7'h30 || o[7:1] == 7'h51) ? 4'h6 : 4'h1;
   endfunction
   // Opcode of the running instruction and how long busy has stood
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         opc_ff <= 8'h00;
         cnt_ff <= 4'h0;
      end else begin
         if (issue)
            opc_ff <= AVS_WRITEDATA[7:0];
         cnt_ff <= BUSY ? cnt_ff + 4'h1 : 4'h0;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_cycles; $fell(BUSY) |-> cnt_ff == cyc(opc_ff); endproperty
   a_cycles: assert property (p_cycles) else $error("busy length wrong");
   property p_ans; take |=> !AVS_WAITREQUEST; endproperty
   a_ans: assert property (p_ans) else $error("no answer after accepted access");
   property p_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
   a_one: assert property (p_one) else $error("waitrequest low too long");
   property p_issue; issue |=> BUSY; endproperty
   a_issue: assert property (p_issue) else $error("instruction not started");
   property p_hold; BUSY ##1 BUSY |-> $stable(FLAGS); endproperty
   a_hold: assert property (p_hold) else $error("flags moved mid instruction");
   property p_ctog; $fell(BUSY) && opc_ff == 8'hEF |-> FLAGS == ($past(FLAGS) ^ 8'h80);
   endproperty
   a_ctog: assert property (p_ctog) else $error("carry toggle flags wrong");
   property p_keep; $fell(BUSY) && opc_ff[7:1] == 7'h40 |-> FLAGS == $past(FLAGS); endproperty
   a_keep: assert property (p_keep) else $error("zero fill changed flags");
   property p_inv; $fell(BUSY) && opc_ff[7:1] == 7'h30 |-> !FLAGS[4] && !(FLAGS[6] && FLAGS[5])
      && FLAGS[7] == $past(FLAGS[7]) && FLAGS[3:0] == $past(FLAGS[3:0]); endproperty
   a_inv: assert property (p_inv) else $error("invert flags wrong");
   property p_cmp; $fell(BUSY) && opc_ff >= 8'hA2 && opc_ff <= 8'hA7 |->
      FLAGS[3:0] == $past(FLAGS[3:0]) && (!FLAGS[6] || FLAGS[7:4] == 4'h4); endproperty
   a_cmp: assert property (p_cmp) else $error("compare flags wrong");
   c_ctog: cover property ($fell(BUSY) && opc_ff == 8'hEF);
   c_long: cover property ($fell(BUSY) && opc_ff == 8'hA7);
   c_stall: cover property (BUSY && AVS_READ);
endmodule // ccu_exec_chk

// >>> bench/testbench.sv
// Random instruction bench for the execution unit with a reference model
`timescale 1ns/1ps
`include "ccu_map.vh"
module testbench;
   reg CLK, RST, AVS_READ, AVS_WRITE;
   reg [11:0] AVS_ADDRESS;
   reg [31:0] AVS_WRITEDATA, q;
   reg [3:0] AVS_BYTEENABLE, g;
   wire [31:0] AVS_READDATA;
   wire AVS_WAITREQUEST, BUSY;
   wire [7:0] FLAGS;
   reg [7:0] mem [0:255];
   reg [7:0] tab [0:13];
   reg [7:0] op, b1, b2, f, f0, a, sv, r, da, sa, corr;
   reg [8:0] dif;
   integer err_count, n_tests, i, b0;
   integer bcnt = 0;
   ccu_exec #(.AW(12)) ccu_exec_inst (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLAGS(FLAGS), .BUSY(BUSY));
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   // Busy cycles seen since the start of the run; the difference across an issue gives its length
   always @(posedge CLK) if (BUSY === 1'b1) bcnt <= bcnt + 1;
   function [7:0] res(input [7:0] b);
      res = (b[7:4] == 4'hE) ? {g, b[3:0]} : b;
   endfunction
   function [3:0] ecyc(input [7:0] o);
      ecyc = (o[7:2] == 6'h29) ? 4'hA : (o[7:1] == 7'h20) ? 4'h8 : (o == 8'h00) ? 4'h1 : 4'h6;
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One bus access; held until waitrequest is seen low, so stalls while busy too
   task bus(input rd, input [11:0] ad, input [31:0] d);
      integer t;
      begin
         @(posedge CLK);
         AVS_ADDRESS <= ad;
         AVS_WRITEDATA <= d;
         AVS_READ <= rd;
         AVS_WRITE <= !rd;
         t = 0;
         @(posedge CLK);
         while (AVS_WAITREQUEST !== 1'b0 && t < 200) begin
            @(posedge CLK);
            t = t + 1;
         end
         q = AVS_READDATA;
         if (t == 200) err_count = err_count + 1;
         AVS_READ <= 1'b0;
         AVS_WRITE <= 1'b0;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      #200000;
      err_count = err_count + 1;
      final_report;
   end
   initial begin
      {RST, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = {3'b100, 44'h0};
      AVS_BYTEENABLE = 4'hF;
      err_count = 0;
      n_tests = 0;
      q = $urandom(32'h90C8);
      tab = '{8'hEF, 8'h80, 8'h81, 8'h60, 8'h61, 8'h40, 8'h41,
         8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'h00};
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      // Reset values, unmapped word at 0x010 included
      for (i = 0; i < 20; i = i + 4) begin
         bus(1, i[11:0], 0);
         chk(q, 0);
      end
      q = $urandom;
      g = q[3:0];
      bus(0, `CCU_OFS_RPTR, g);
      bus(1, `CCU_OFS_RPTR, 0);
      chk(q, g);
      // Flag write with byte lane 0 off must be ignored
      AVS_BYTEENABLE <= 4'hE;
      bus(0, `CCU_OFS_FLAGS, 32'h000000FF);
      AVS_BYTEENABLE <= 4'hF;
      bus(1, `CCU_OFS_FLAGS, 0);
      chk(q, 0);
      for (i = 0; i < 256; i = i + 1) begin
         q = $urandom;
         mem[i] = q[7:0];
         bus(0, {2'b01, i[7:0], 2'b00}, mem[i]);
      end
      // Every opcode once, then random ones; model runs beside the design
      for (i = 0; i < 80; i = i + 1) begin
         op = (i < 14) ? tab[i] : tab[$urandom % 14];
         q = $urandom;
         {b2, b1, f0} = q[23:0];
         if (i % 3 == 0) b1[7:4] = 4'hE;
         f = f0;
         case (op)
            8'hA2, 8'hA3: {da, sa} = {g, b1[7:4], g, b1[3:0]};
            8'hA4, 8'hA5: {da, sa} = {res(b2), res(b1)};
            default: {da, sa} = {res(b1), 8'h00};
         endcase
         if (op == 8'hA3 || op == 8'hA5) sa = mem[sa];
         if (op[0] && op != 8'hEF && op != 8'hA3 && op != 8'hA5) da = mem[da];
         a = mem[da];
         sv = (op[7:1] == 7'h53) ? b2 : mem[sa];
         if (i % 5 == 1 && op[7:1] == 7'h53) {b2, sv} = {a, a};
         case (op)
            8'hEF: f[7] = ~f[7];
            8'h80, 8'h81: mem[da] = 8'h00;
            8'h60, 8'h61: begin
               r = ~a;
               mem[da] = r;
               f[7:4] = {f[7], r == 8'h00, r[7], 1'b0};
            end
            8'h40, 8'h41: begin
               // D set: subtraction corrections, both together wrap to 9A
               if (f[3])
                  corr = (f[7] ? 8'hA0 : 8'h00) + (f[2] ? 8'hFA : 8'h00);
               else
                  corr = ((f[7] || a > 8'h99) ? 8'h60 : 8'h00)
                     | ((f[2] || a[3:0] > 4'h9) ? 8'h06 : 8'h00);
               r = a + corr;
               mem[da] = r;
               f[7:5] = {f[3] ? f[7] : corr[6], r == 8'h00, r[7]};
            end
            8'h00: f = f0;
            default: begin
               dif = {1'b0, a} + {1'b0, ~sv} + 9'h001;
               r = dif[7:0];
               f[7:4] = {~dif[8], r == 8'h00, r[7],
                  a[7] != sv[7] && r[7] != a[7]};
            end
         endcase
         bus(0, `CCU_OFS_FLAGS, {24'h0, f0});
         b0 = bcnt;
         bus(0, `CCU_OFS_INSTR, {8'h00, b2, b1, op});
         bus(1, `CCU_OFS_FLAGS, 0);
         chk(bcnt - b0, ecyc(op));
         chk(q, f);
         chk(FLAGS, f);
         bus(1, `CCU_OFS_STATUS, 0);
         chk(q, {30'h0, op == 8'h00, 1'b0});
         bus(1, {2'b01, da, 2'b00}, 0);
         chk(q, mem[da]);
      end
      final_report;
   end
endmodule // testbench
bind ccu_exec ccu_exec_chk #(.AW(AW)) ccu_exec_chk_inst (.CLK(CLK), .RST(RST),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLAGS(FLAGS), .BUSY(BUSY));
